// >>> logic/ecb_budget_if.sv
// Lookup port between the sequencer and its budget table.
// Assumes both ends sit in the core clock domain; purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface ecb_budget_if;
   import ecb_pkg::*;
   ecb_op_type     op;      // Operation to look up.
   ecb_case_type   sel;     // Timing case to look up.
   ecb_budget_type budget;  // Budget returned by the table.

   // The table answers; the sequencer asks.
   modport table_side (input op, input sel, output budget);
   modport seq_side   (output op, output sel, input budget);
endinterface : ecb_budget_if
`default_nettype wire

// >>> logic/ecb_budget_table.sv
// Budget table: maps an operation and timing case to its bus budget.
// Assumes the asker holds op and sel stable for the cycle it samples.
`timescale 1ns/100ps
`default_nettype none
module ecb_budget_table
   import ecb_pkg::*;
(
   // Lookup port.
   ecb_budget_if.table_side lk
);

   // Unknown operation codes get a one-clock budget with no bus cycles,
   // so a bad request can never hang the sequencer.
   always_comb begin
      if (int'(lk.op) < ECB_OP_COUNT) begin
         lk.budget = ECB_TABLE[int'(lk.op)][int'(ecb_case_fix(lk.sel))];
      end else begin
         lk.budget = ECB_ILLEGAL_BUDGET;
      end
   end

endmodule : ecb_budget_table
`default_nettype wire

// >>> logic/ecb_exception_sequencer.sv
// Exception sequencer: spends each operation's clock budget and issues
// read, prefetch and write bus-cycle pulses within it.
// Assumes a bus unit that takes one pulse per cycle without stalling.
`timescale 1ns/100ps
`default_nettype none
module ecb_exception_sequencer
   import ecb_pkg::*;
(
   // Clock and reset.
   input  wire  logic        core_clk,
   input  wire  logic        rst_n,
   // Request.
   input  wire  logic        req_valid,
   input  wire  ecb_op_type  req_op,
   input  wire  logic [1:0]  req_case,
   input  wire  ecb_op_type  req_next_op,
   // Status.
   output logic              busy,
   output logic              done,
   // Bus-cycle pulses.
   output logic              bus_read,
   output logic              bus_prefetch,
   output logic              bus_write
);

   // Sequencer states.
   typedef enum logic [0:0] {
      ECB_ST_IDLE = 1'b0,
      ECB_ST_RUN  = 1'b1
   } ecb_state_type;

   ecb_budget_if bif ();                      // Table lookup port.

   ecb_state_type  state_ff, nxt_state;       // Current state.
   ecb_budget_type budget_ff, nxt_budget;     // Budget being spent.
   logic [9:0]     cnt_ff, nxt_cnt;           // Clocks spent so far.
   logic           chain_ff, nxt_chain;       // Second frame pending.
   ecb_op_type     next_op_ff, nxt_next_op;   // Second frame kind.
   ecb_case_type   case_ff, nxt_case;         // Latched timing case.
   logic           busy_ff, nxt_busy;         // Operation in progress.
   logic           done_ff, nxt_done;         // Completion pulse.
   logic [2:0]     slot_ff, nxt_slot;         // {read,prefetch,write}.

   ecb_budget_table u_table (.lk(bif));

   // While idle the table sees the new request; while running it sees
   // the second frame, so the chain can load with no dead clock.
   assign bif.op  = (state_ff == ECB_ST_IDLE) ? req_op : next_op_ff;
   assign bif.sel = (state_ff == ECB_ST_IDLE) ? ecb_case_fix(req_case)
                                              : case_ff;

   // Next-state logic; requests while busy are ignored.
   always_comb begin
      nxt_state   = state_ff;
      nxt_budget  = budget_ff;
      nxt_cnt     = cnt_ff;
      nxt_chain   = chain_ff;
      nxt_next_op = next_op_ff;
      nxt_case    = case_ff;
      nxt_busy    = busy_ff;
      nxt_done    = 1'b0;
      nxt_slot    = 3'h0;
      unique case (state_ff)
         ECB_ST_IDLE: begin
            if (req_valid) begin
               // Start at clock 0 of the looked-up budget.
               nxt_state   = ECB_ST_RUN;
               nxt_budget  = bif.budget;
               nxt_cnt     = 10'h000;
               nxt_chain   = (req_op == ECB_OP_RTE_THROWAWAY);
               nxt_next_op = req_next_op;
               nxt_case    = ecb_case_fix(req_case);
               nxt_busy    = 1'b1;
               nxt_slot    = ecb_slot(10'h000, bif.budget);
            end
         end
         ECB_ST_RUN: begin
            if (cnt_ff != budget_ff.clocks - ECB_ONE_CLK) begin
               // Spend one more clock of the budget.
               nxt_cnt  = cnt_ff + ECB_ONE_CLK;
               nxt_slot = ecb_slot(cnt_ff + ECB_ONE_CLK, budget_ff);
            end else if (chain_ff) begin
               // Throwaway frame over: the second frame's time follows.
               nxt_budget = bif.budget;
               nxt_cnt    = 10'h000;
               nxt_chain  = 1'b0;
               nxt_slot   = ecb_slot(10'h000, bif.budget);
            end else begin
               // Budget spent; report and return to idle.
               nxt_state = ECB_ST_IDLE;
               nxt_busy  = 1'b0;
               nxt_done  = 1'b1;
            end
         end
      endcase
   end

   // State registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= ECB_ST_IDLE;
         budget_ff  <= ECB_ILLEGAL_BUDGET;
         cnt_ff     <= 10'h000;
         chain_ff   <= 1'b0;
         next_op_ff <= ECB_OP_RTE_NORMAL;
         case_ff    <= ECB_CASE_BEST;
         busy_ff    <= 1'b0;
         done_ff    <= 1'b0;
         slot_ff    <= 3'h0;
      end else begin
         state_ff   <= nxt_state;
         budget_ff  <= nxt_budget;
         cnt_ff     <= nxt_cnt;
         chain_ff   <= nxt_chain;
         next_op_ff <= nxt_next_op;
         case_ff    <= nxt_case;
         busy_ff    <= nxt_busy;
         done_ff    <= nxt_done;
         slot_ff    <= nxt_slot;
      end
   end

   // Outputs straight from flip-flops.
   assign busy         = busy_ff;
   assign done         = done_ff;
   assign bus_read     = slot_ff[2];
   assign bus_prefetch = slot_ff[1];
   assign bus_write    = slot_ff[0];

   // Checking helpers: count busy clocks and pulses over one request.
   ecb_op_type     h_op_ff, nxt_h_op;      // Operation that started it.
   ecb_op_type     h_next_ff, nxt_h_next;  // Second frame of it.
   ecb_case_type   h_case_ff, nxt_h_case;  // Its timing case.
   logic [10:0]    h_clk_ff, nxt_h_clk;    // Busy clocks counted.
   logic [5:0]     h_rd_ff, nxt_h_rd;      // Read pulses counted.
   logic [5:0]     h_pf_ff, nxt_h_pf;      // Prefetch pulses counted.
   logic [5:0]     h_wr_ff, nxt_h_wr;      // Write pulses counted.
   logic           h_ok;                   // Counts match one budget.
   logic           h_chain_ok;             // Counts match both frames.
   ecb_budget_type h_a;                    // Budget of the request.
   ecb_budget_type h_b;                    // Budget of its second frame.

   // Helper next values: a taken request restarts the counts; otherwise
   // they add up busy clocks and pulses as the registers show them.
   always_comb begin
      nxt_h_op   = h_op_ff;
      nxt_h_next = h_next_ff;
      nxt_h_case = h_case_ff;
      nxt_h_clk  = h_clk_ff + {10'h000, busy_ff};
      nxt_h_rd   = h_rd_ff + {5'h00, bus_read};
      nxt_h_pf   = h_pf_ff + {5'h00, bus_prefetch};
      nxt_h_wr   = h_wr_ff + {5'h00, bus_write};
      if ((state_ff == ECB_ST_IDLE) && req_valid) begin
         nxt_h_op   = req_op;
         nxt_h_next = req_next_op;
         nxt_h_case = ecb_case_fix(req_case);
         nxt_h_clk  = 11'h000;
         nxt_h_rd   = 6'h00;
         nxt_h_pf   = 6'h00;
         nxt_h_wr   = 6'h00;
      end
   end

   // Helper registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         h_op_ff   <= ECB_OP_STOP;
         h_next_ff <= ECB_OP_RTE_NORMAL;
         h_case_ff <= ECB_CASE_BEST;
         h_clk_ff  <= 11'h000;
         h_rd_ff   <= 6'h00;
         h_pf_ff   <= 6'h00;
         h_wr_ff   <= 6'h00;
      end else begin
         h_op_ff   <= nxt_h_op;
         h_next_ff <= nxt_h_next;
         h_case_ff <= nxt_h_case;
         h_clk_ff  <= nxt_h_clk;
         h_rd_ff   <= nxt_h_rd;
         h_pf_ff   <= nxt_h_pf;
         h_wr_ff   <= nxt_h_wr;
      end
   end

   always_comb begin
      h_a = ECB_TABLE[int'(h_op_ff) % ECB_OP_COUNT][int'(h_case_ff)];
      h_b = ECB_TABLE[int'(h_next_ff) % ECB_OP_COUNT][int'(h_case_ff)];
      h_ok = (h_clk_ff == {1'b0, h_a.clocks}) &&
             (h_rd_ff == {1'b0, h_a.reads}) &&
             (h_pf_ff == {4'h0, h_a.prefetches}) &&
             (h_wr_ff == {1'b0, h_a.writes});
      h_chain_ok = (h_clk_ff == {1'b0, h_a.clocks} + {1'b0, h_b.clocks}) &&
                   (h_rd_ff == {1'b0, h_a.reads} + {1'b0, h_b.reads}) &&
                   (h_pf_ff == {4'h0, h_b.prefetches}) &&
                   (h_wr_ff == {1'b0, h_b.writes});
   end

   // A finished request of kind o spent exactly its tabled budget.
   property budget_p(ecb_op_type o);
      @(posedge core_clk) disable iff (!rst_n)
      (done_ff && (h_op_ff == o)) |-> h_ok;
   endproperty

   breakpoint_instruction_budget_a:    assert property (budget_p(ECB_OP_BREAKPOINT))
      else $error("breakpoint budget wrong");
   istack_budget_a:  assert property (budget_p(ECB_OP_INT_ISTACK))
      else $error("interrupt stack entry budget wrong");
   mstack_budget_a:  assert property (budget_p(ECB_OP_INT_MSTACK))
      else $error("master stack entry budget wrong");
   reset_nobus_a:    assert property (@(posedge core_clk)
      disable iff (!rst_n) (busy_ff && (h_op_ff == ECB_OP_RESET_INSTR))
      |-> !bus_read && !bus_write && (h_clk_ff < {1'b0, h_a.clocks}))
      else $error("reset instruction used bus or overran");
   trace_budget_a:   assert property (budget_p(ECB_OP_TRACE))
      else $error("trace budget wrong");
   trap_budget_a:    assert property (budget_p(ECB_OP_TRAP_GROUP))
      else $error("trap group budget wrong");
   ctrap_taken_a:    assert property (@(posedge core_clk)
      disable iff (!rst_n) (done_ff && ((h_op_ff == ECB_OP_CTRAP_TAKEN) ||
      (h_op_ff == ECB_OP_CTRAP_WL_TAKEN))) |-> h_ok && (h_wr_ff == 6'h05))
      else $error("taken conditional trap budget wrong");
   ctrap_skip_a:     assert property (@(posedge core_clk)
      disable iff (!rst_n) (done_ff && (h_op_ff >= ECB_OP_CTRAP_NT) &&
      (h_op_ff <= ECB_OP_CTRAP_L_NT)) |-> h_ok && (h_wr_ff == 6'h00))
      else $error("untaken conditional trap budget wrong");
   ovf_trap_a:       assert property (@(posedge core_clk)
      disable iff (!rst_n) (done_ff && ((h_op_ff == ECB_OP_OVF_TAKEN) ||
      (h_op_ff == ECB_OP_OVF_NT))) |-> h_ok)
      else $error("overflow trap budget wrong");
   fault_short_a:    assert property (budget_p(ECB_OP_FAULT_SHORT))
      else $error("short fault save budget wrong");
   fault_long_a:     assert property (budget_p(ECB_OP_FAULT_LONG))
      else $error("long fault save budget wrong");
   rte_normal_a:     assert property (budget_p(ECB_OP_RTE_NORMAL))
      else $error("normal return budget wrong");
   rte_coproc_a:     assert property (budget_p(ECB_OP_RTE_COPROC))
      else $error("coprocessor return budget wrong");
   rte_fault_a:      assert property (@(posedge core_clk)
      disable iff (!rst_n) (done_ff && ((h_op_ff == ECB_OP_RTE_SHORT_FLT) ||
      (h_op_ff == ECB_OP_RTE_LONG_FLT))) |-> h_ok)
      else $error("fault frame return budget wrong");
   rte_chain_a:      assert property (@(posedge core_clk)
      disable iff (!rst_n) (done_ff && (h_op_ff == ECB_OP_RTE_THROWAWAY) &&
      (h_next_ff != ECB_OP_RTE_THROWAWAY)) |-> h_chain_ok)
      else $error("throwaway return did not add second frame");
   stop_hold_a:      assert property (@(posedge core_clk)
      disable iff (!rst_n) ($rose(busy_ff) && (h_op_ff == ECB_OP_STOP))
      |-> (busy_ff && !slot_ff[2] && !slot_ff[1] && !slot_ff[0])[*8]
      ##1 (!busy_ff && done_ff))
      else $error("stop did not take eight quiet clocks");

   // Main scenarios worth seeing.
   breakpoint_instruction_seen_c:  cover property (@(posedge core_clk) disable iff (!rst_n)
      done_ff && (h_op_ff == ECB_OP_BREAKPOINT));
   chain_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      done_ff && (h_op_ff == ECB_OP_RTE_THROWAWAY));
   worst_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n)
      done_ff && (h_case_ff == ECB_CASE_WORST) && (h_pf_ff != 6'h00));
   b2b_seen_c:   cover property (@(posedge core_clk) disable iff (!rst_n)
      done_ff && req_valid);

endmodule : ecb_exception_sequencer
`default_nettype wire

// >>> logic/ecb_pkg.sv
// Shared types and cycle budgets for the exception sequencer.
// Assumes one 250 MHz core clock and a bus unit that runs each pulse.
`default_nettype none
package ecb_pkg;

   // Operations; six-word return shares the normal return budget.
   typedef enum logic [4:0] {
      ECB_OP_BREAKPOINT    = 5'h00,
      ECB_OP_INT_ISTACK    = 5'h01,
      ECB_OP_INT_MSTACK    = 5'h02,
      ECB_OP_RESET_INSTR   = 5'h03,
      ECB_OP_STOP          = 5'h04,
      ECB_OP_TRACE         = 5'h05,
      ECB_OP_TRAP_GROUP    = 5'h06,
      ECB_OP_CTRAP_TAKEN   = 5'h07,
      ECB_OP_CTRAP_WL_TAKEN = 5'h08,
      ECB_OP_CTRAP_NT      = 5'h09,
      ECB_OP_CTRAP_W_NT    = 5'h0a,
      ECB_OP_CTRAP_L_NT    = 5'h0b,
      ECB_OP_OVF_TAKEN     = 5'h0c,
      ECB_OP_OVF_NT        = 5'h0d,
      ECB_OP_FAULT_SHORT   = 5'h0e,
      ECB_OP_FAULT_LONG    = 5'h0f,
      ECB_OP_RTE_NORMAL    = 5'h10,
      ECB_OP_RTE_COPROC    = 5'h11,
      ECB_OP_RTE_SHORT_FLT = 5'h12,
      ECB_OP_RTE_LONG_FLT  = 5'h13,
      ECB_OP_RTE_THROWAWAY = 5'h14
   } ecb_op_type;

   // Timing case; code 3 is read as worst case.
   typedef enum logic [1:0] {
      ECB_CASE_BEST  = 2'h0,
      ECB_CASE_CACHE = 2'h1,
      ECB_CASE_WORST = 2'h2
   } ecb_case_type;

   // One budget: total clocks and counts of read, prefetch, write.
   typedef struct packed {
      logic [9:0] clocks;
      logic [4:0] reads;
      logic [1:0] prefetches;
      logic [4:0] writes;
   } ecb_budget_type;

   localparam int             ECB_OP_COUNT   = 21;
   localparam int             ECB_CASE_COUNT = 3;
   localparam logic [9:0]     ECB_ONE_CLK    = 10'h001;
   localparam ecb_budget_type ECB_ILLEGAL_BUDGET =
      '{10'h001, 5'h00, 2'h0, 5'h00};

   // Budget table, indexed by operation then timing case.
   localparam ecb_budget_type ECB_TABLE [ECB_OP_COUNT][ECB_CASE_COUNT] = '{
      '{'{10'h009,5'h01,2'h0,5'h00}, '{10'h00a,5'h01,2'h0,5'h00},
        '{10'h00a,5'h01,2'h0,5'h00}},
      '{'{10'h01a,5'h02,2'h0,5'h04}, '{10'h01a,5'h02,2'h0,5'h04},
        '{10'h021,5'h02,2'h2,5'h04}},
      '{'{10'h029,5'h02,2'h0,5'h08}, '{10'h029,5'h02,2'h0,5'h08},
        '{10'h030,5'h02,2'h2,5'h08}},
      '{'{10'h206,5'h00,2'h0,5'h00}, '{10'h206,5'h00,2'h0,5'h00},
        '{10'h207,5'h00,2'h1,5'h00}},
      '{'{10'h008,5'h00,2'h0,5'h00}, '{10'h008,5'h00,2'h0,5'h00},
        '{10'h008,5'h00,2'h0,5'h00}},
      '{'{10'h019,5'h01,2'h0,5'h05}, '{10'h019,5'h01,2'h0,5'h05},
        '{10'h020,5'h01,2'h2,5'h05}},
      '{'{10'h014,5'h01,2'h0,5'h04}, '{10'h014,5'h01,2'h0,5'h04},
        '{10'h01b,5'h01,2'h2,5'h04}},
      '{'{10'h017,5'h01,2'h0,5'h05}, '{10'h019,5'h01,2'h0,5'h05},
        '{10'h020,5'h01,2'h2,5'h05}},
      '{'{10'h017,5'h01,2'h0,5'h05}, '{10'h019,5'h01,2'h0,5'h05},
        '{10'h021,5'h01,2'h3,5'h05}},
      '{'{10'h001,5'h00,2'h0,5'h00}, '{10'h004,5'h00,2'h0,5'h00},
        '{10'h005,5'h00,2'h1,5'h00}},
      '{'{10'h003,5'h00,2'h0,5'h00}, '{10'h006,5'h00,2'h0,5'h00},
        '{10'h007,5'h00,2'h1,5'h00}},
      '{'{10'h005,5'h00,2'h0,5'h00}, '{10'h008,5'h00,2'h0,5'h00},
        '{10'h00a,5'h00,2'h2,5'h00}},
      '{'{10'h017,5'h01,2'h0,5'h05}, '{10'h019,5'h01,2'h0,5'h05},
        '{10'h020,5'h01,2'h2,5'h05}},
      '{'{10'h001,5'h00,2'h0,5'h00}, '{10'h004,5'h00,2'h0,5'h00},
        '{10'h005,5'h00,2'h1,5'h00}},
      '{'{10'h02a,5'h01,2'h0,5'h0a}, '{10'h02b,5'h01,2'h0,5'h0a},
        '{10'h032,5'h01,2'h2,5'h0a}},
      '{'{10'h04f,5'h01,2'h0,5'h18}, '{10'h04f,5'h01,2'h0,5'h18},
        '{10'h056,5'h01,2'h2,5'h18}},
      '{'{10'h014,5'h04,2'h0,5'h00}, '{10'h015,5'h04,2'h0,5'h00},
        '{10'h018,5'h04,2'h2,5'h00}},
      '{'{10'h01f,5'h07,2'h0,5'h00}, '{10'h020,5'h07,2'h0,5'h00},
        '{10'h021,5'h07,2'h1,5'h00}},
      '{'{10'h02a,5'h0a,2'h0,5'h00}, '{10'h02b,5'h0a,2'h0,5'h00},
        '{10'h02d,5'h0a,2'h2,5'h00}},
      '{'{10'h05b,5'h18,2'h0,5'h00}, '{10'h05c,5'h18,2'h0,5'h00},
        '{10'h05e,5'h18,2'h2,5'h00}},
      '{'{10'h00f,5'h04,2'h0,5'h00}, '{10'h010,5'h04,2'h0,5'h00},
        '{10'h027,5'h04,2'h0,5'h00}}
   };

   // Folds the unused case code onto worst case.
   function automatic ecb_case_type ecb_case_fix(input logic [1:0] sel);
      ecb_case_fix = (sel > ECB_CASE_WORST) ? ECB_CASE_WORST
                                            : ecb_case_type'(sel);
   endfunction : ecb_case_fix

   // Bus slot at clock k: reads first, then prefetches, then writes.
   function automatic logic [2:0] ecb_slot(input logic [9:0] k,
                                           input ecb_budget_type b);
      logic [9:0] r_end;
      logic [9:0] p_end;
      logic [9:0] w_end;
      r_end = {5'h00, b.reads};
      p_end = r_end + {8'h00, b.prefetches};
      w_end = p_end + {5'h00, b.writes};
      ecb_slot = {k < r_end, (k >= r_end) && (k < p_end),
                  (k >= p_end) && (k < w_end)};
   endfunction : ecb_slot

endpackage : ecb_pkg
`default_nettype wire

// >>> sim/ecb_mem_model.sv
// Behavioural system-memory model that takes the sequencer's bus pulses.
// Assumes pulses are one-cycle, registered on core_clk, never stalled.
`timescale 1ns/100ps
`default_nettype none
module ecb_mem_model (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Sequencer status and bus pulses.
   input  wire logic busy,
   input  wire logic bus_read,
   input  wire logic bus_prefetch,
   input  wire logic bus_write,
   // Running totals for the bench.
   output var  int   reads,
   output var  int   prefetches,
   output var  int   writes,
   output var  int   order_errs
);
   int phase_ff;  // 0 reads, 1 prefetches, 2 writes seen so far.

   // Memory accepts one cycle a clock; it counts them and flags a read
   // after a prefetch or write, or two cycles in one clock, as abuse.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff   <= 0;
         reads      <= 0;
         prefetches <= 0;
         writes     <= 0;
         order_errs <= 0;
      end else begin
         if (bus_read === 1'b1) begin
            reads <= reads + 1;
            if (phase_ff > 0) order_errs <= order_errs + 1;
         end
         if (bus_prefetch === 1'b1) begin
            prefetches <= prefetches + 1;
            if (phase_ff > 1 || bus_read === 1'b1) begin
               order_errs <= order_errs + 1;
            end
            phase_ff <= 1;
         end
         if (bus_write === 1'b1) begin
            writes <= writes + 1;
            if (bus_read === 1'b1 || bus_prefetch === 1'b1) begin
               order_errs <= order_errs + 1;
            end
            phase_ff <= 2;
         end
         // A cycle outside a busy period has no owner.
         if ((bus_read | bus_prefetch | bus_write) === 1'b1 && !busy) begin
            order_errs <= order_errs + 1;
         end
         if (busy !== 1'b1) phase_ff <= 0;
      end
   end
endmodule : ecb_mem_model
`default_nettype wire

// >>> sim/test_exception_cycle_budget.sv
// Self-checking bench for the exception sequencer's cycle budgets.
// Assumes the sequencer top, ecb_pkg and the memory model are compiled.
`timescale 1ns/100ps
`default_nettype none
module test_exception_cycle_budget;
   import ecb_pkg::*;

   // One row: request and the clocks and bus cycles it should spend.
   typedef struct {
      ecb_op_type op;
      logic [1:0] cs;
      int         clk, r, p, w;
   } ecb_row_type;

   logic       core_clk;     // 250 MHz core clock.
   logic       rst_n;        // Asynchronous reset, active low.
   logic       req_valid;    // Request strobe.
   ecb_op_type req_op;       // Requested operation.
   logic [1:0] req_case;     // Timing case.
   ecb_op_type req_next_op;  // Second frame after a throwaway return.
   logic       busy, done, bus_read, bus_prefetch, bus_write;
   int         mem_r, mem_p, mem_w, mem_e;  // Memory model totals.
   int         miscompares = 0;             // Mismatches seen.
   int         checked = 0;                 // Comparisons made.

   // Ordinary cases, best/cache/worst and the spare code 3.
   ecb_row_type rows [] = '{
      '{ECB_OP_BREAKPOINT,2'h0,9,1,0,0},
      '{ECB_OP_BREAKPOINT,2'h2,10,1,0,0},
      '{ECB_OP_INT_ISTACK,2'h0,26,2,0,4},
      '{ECB_OP_INT_ISTACK,2'h2,33,2,2,4},
      '{ECB_OP_INT_MSTACK,2'h1,41,2,0,8},
      '{ECB_OP_INT_MSTACK,2'h3,48,2,2,8},
      '{ECB_OP_RESET_INSTR,2'h0,518,0,0,0},
      '{ECB_OP_RESET_INSTR,2'h2,519,0,1,0},
      '{ECB_OP_TRACE,2'h0,25,1,0,5},
      '{ECB_OP_TRACE,2'h2,32,1,2,5},
      '{ECB_OP_TRAP_GROUP,2'h0,20,1,0,4},
      '{ECB_OP_TRAP_GROUP,2'h2,27,1,2,4},
      '{ECB_OP_CTRAP_TAKEN,2'h0,23,1,0,5},
      '{ECB_OP_CTRAP_TAKEN,2'h1,25,1,0,5},
      '{ECB_OP_CTRAP_TAKEN,2'h2,32,1,2,5},
      '{ECB_OP_CTRAP_WL_TAKEN,2'h2,33,1,3,5},
      '{ECB_OP_CTRAP_NT,2'h0,1,0,0,0},
      '{ECB_OP_CTRAP_W_NT,2'h0,3,0,0,0},
      '{ECB_OP_CTRAP_L_NT,2'h0,5,0,0,0},
      '{ECB_OP_CTRAP_L_NT,2'h2,10,0,2,0},
      '{ECB_OP_OVF_TAKEN,2'h0,23,1,0,5},
      '{ECB_OP_OVF_NT,2'h0,1,0,0,0},
      '{ECB_OP_OVF_NT,2'h2,5,0,1,0},
      '{ECB_OP_FAULT_SHORT,2'h0,42,1,0,10},
      '{ECB_OP_FAULT_SHORT,2'h2,50,1,2,10},
      '{ECB_OP_FAULT_LONG,2'h0,79,1,0,24},
      '{ECB_OP_FAULT_LONG,2'h2,86,1,2,24},
      '{ECB_OP_RTE_NORMAL,2'h0,20,4,0,0},
      '{ECB_OP_RTE_NORMAL,2'h2,24,4,2,0},
      '{ECB_OP_RTE_COPROC,2'h0,31,7,0,0},
      '{ECB_OP_RTE_COPROC,2'h2,33,7,1,0},
      '{ECB_OP_RTE_SHORT_FLT,2'h0,42,10,0,0},
      '{ECB_OP_RTE_SHORT_FLT,2'h2,45,10,2,0},
      '{ECB_OP_RTE_LONG_FLT,2'h0,91,24,0,0},
      '{ECB_OP_RTE_LONG_FLT,2'h2,94,24,2,0},
      '{ECB_OP_STOP,2'h2,8,0,0,0}
   };

   ecb_exception_sequencer dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req_op(req_op), .req_case(req_case), .req_next_op(req_next_op),
      .busy(busy), .done(done), .bus_read(bus_read),
      .bus_prefetch(bus_prefetch), .bus_write(bus_write)
   );

   ecb_mem_model mem_u (
      .core_clk(core_clk), .rst_n(rst_n), .busy(busy),
      .bus_read(bus_read), .bus_prefetch(bus_prefetch),
      .bus_write(bus_write), .reads(mem_r), .prefetches(mem_p),
      .writes(mem_w), .order_errs(mem_e)
   );

   // Clock generator.
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Records one comparison and reports it at once if it fails.
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         miscompares++;
         $display("BAD t=%0t %s", $time, msg);
      end
   endtask : chk

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Called at the taking edge: counts busy clocks and bus cycles.
   task automatic measure(input int ec, input int er, input int ep,
                          input int ew);
      int n, r0, p0, w0, e0;
      #1;
      r0 = mem_r; p0 = mem_p; w0 = mem_w; e0 = mem_e;
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         n++;
         @(posedge core_clk);
         #1;
      end
      chk(n == ec, $sformatf("busy %0d want %0d", n, ec));
      chk(done === 1'b1, "no done pulse after busy");
      chk(mem_r - r0 == er && mem_p - p0 == ep && mem_w - w0 == ew,
          $sformatf("bus r/p/w %0d/%0d/%0d", mem_r-r0, mem_p-p0, mem_w-w0));
      chk(mem_e == e0, "bus cycles out of order");
   endtask : measure

   // Presents one request for a single edge and measures it.
   task automatic run_op(input ecb_op_type op, input logic [1:0] cs,
                         input ecb_op_type nxt, input int ec,
                         input int er, input int ep, input int ew);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_case <= cs;
      req_next_op <= nxt;
      @(posedge core_clk);
      req_valid <= 1'b0;
      measure(ec, er, ep, ew);
   endtask : run_op

   // Watchdog: the whole sequence needs well under 5000 clocks.
   initial begin
      #80000;
      miscompares++;
      $display("BAD t=%0t watchdog expired", $time);
      print_verdict();
   end

   // Main sequence.
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_op = ECB_OP_STOP;
      req_case = 2'h0;
      req_next_op = ECB_OP_RTE_NORMAL;
      repeat (8) @(posedge core_clk);
      chk({busy, done, bus_read, bus_prefetch, bus_write} === 5'h00,
          "outputs not idle in reset");
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk({busy, done, bus_read, bus_prefetch, bus_write} === 5'h00,
          "outputs not idle after reset");
      foreach (rows[i]) begin
         run_op(rows[i].op, rows[i].cs, ECB_OP_STOP, rows[i].clk,
                rows[i].r, rows[i].p, rows[i].w);
      end
      // Throwaway frame followed by its second frame, best and worst.
      run_op(ECB_OP_RTE_THROWAWAY, 2'h0, ECB_OP_RTE_NORMAL,
             35, 8, 0, 0);
      run_op(ECB_OP_RTE_THROWAWAY, 2'h2, ECB_OP_RTE_COPROC,
             72, 11, 1, 0);
      // Unused operation code runs one quiet clock.
      run_op(ecb_op_type'(5'h15), 2'h0, ECB_OP_STOP, 1, 0, 0, 0);
      // Request held through a busy period: ignored, then taken at done.
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_op <= ECB_OP_BREAKPOINT;
      req_case <= 2'h0;
      @(posedge core_clk);
      req_op <= ECB_OP_STOP;
      measure(9, 1, 0, 0);
      @(posedge core_clk);
      req_valid <= 1'b0;
      measure(8, 0, 0, 0);
      // Reset in the middle of a long reset instruction.
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_op <= ECB_OP_RESET_INSTR;
      @(posedge core_clk);
      req_valid <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b0;
      @(posedge core_clk);
      #1;
      chk({busy, done} === 2'h0, "busy survives reset");
      @(posedge core_clk);
      rst_n <= 1'b1;
      run_op(ECB_OP_BREAKPOINT, 2'h1, ECB_OP_STOP, 10, 1, 0, 0);
      print_verdict();
   end
endmodule : test_exception_cycle_budget
`default_nettype wire
